/* File: hw/ums_top.sv */
// How it works
// - active-level bit sets cts polarity
// - pin-state bit mirrors sampled cts level
// - any cts edge sets sticky change flag
// - flag and enable raise modem interrupt
// - write one clears change flag
// - channel two: modem register reads zero
// - modem register resets to 0x110
// - fifo status resets to 0x10404000
// - idle only when fifo empty, shifter done
// - idle drops while data queued or sending
// - write when full flags overflow, drops byte
// - overflow: write one clears, never sets
// - full flag when occupancy equals depth
// - empty set when last byte leaves
// - empty clears on holding-port write
// - six-bit transmit level field
// - level counts writes up, loads down
// - full reads level zero; then depth-1
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ums_top import ums_pkg::*; #(
  parameter int CHANNEL = 0,
  parameter int DEPTH = (CHANNEL == 0) ? DEPTH_CH0 : DEPTH_OTHER
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cts_pin,
  output logic cts_asserted,
  output logic modem_irq,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic shift_busy
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic HAS_MODEM = (CHANNEL != NO_MODEM_CHANNEL);

  function automatic logic fn_mapped(input logic [7:0] a);
    return (a == OFS_TX_PORT) || (a == OFS_IER) || (a == OFS_MSR) || (a == OFS_FSR);
  endfunction : fn_mapped

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  ums_wr_state_t wr_state;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_take, w_take, wr_go;
  logic [7:0] cur_addr;
  logic [31:0] cur_data;
  logic [3:0] cur_strb;

  assign s_axi_awready = (wr_state == UMS_WR_WAIT) && !aw_held;
  assign s_axi_wready = (wr_state == UMS_WR_WAIT) && !w_held;
  assign s_axi_bvalid = (wr_state == UMS_WR_RESP);
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_go = (wr_state == UMS_WR_WAIT) && (aw_held || aw_take) && (w_held || w_take);
  assign cur_addr = aw_held ? aw_addr : s_axi_awaddr;
  assign cur_data = w_held ? w_data : s_axi_wdata;
  assign cur_strb = w_held ? w_strb : s_axi_wstrb;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_state <= UMS_WR_WAIT;
    end else begin
      case (wr_state)
        UMS_WR_WAIT: if (wr_go) wr_state <= UMS_WR_RESP;
        UMS_WR_RESP: if (s_axi_bready) wr_state <= UMS_WR_WAIT;
        default: wr_state <= UMS_WR_WAIT;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (wr_go) aw_held <= 1'b0;
      else if (aw_take) aw_held <= 1'b1;
      if (wr_go) w_held <= 1'b0;
      else if (w_take) w_held <= 1'b1;
      if (aw_take) aw_addr <= s_axi_awaddr;
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) s_axi_bresp <= fn_mapped(cur_addr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  logic modem_irq_enable, cts_active_level, cts_change_flag, tx_overflow_flag;
  logic wr_ier, wr_msr, wr_fsr, push_req, push_ok, pop;
  assign wr_ier = wr_go && (cur_addr == OFS_IER);
  assign wr_msr = wr_go && (cur_addr == OFS_MSR) && HAS_MODEM;
  assign wr_fsr = wr_go && (cur_addr == OFS_FSR);
  assign push_req = wr_go && (cur_addr == OFS_TX_PORT) && cur_strb[0];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      modem_irq_enable <= IER_RESET;
      cts_active_level <= MSR_RESET[MSR_LEVEL_BIT];
    end else begin
      if (wr_ier && cur_strb[IER_MODEM_BIT / 8]) modem_irq_enable <= cur_data[IER_MODEM_BIT];
      if (wr_msr && cur_strb[MSR_LEVEL_BIT / 8]) cts_active_level <= cur_data[MSR_LEVEL_BIT];
    end
  end

  // ----------------------------------------
  // cts synchronizer and change flag
  // ----------------------------------------
  logic cts_meta, cts_pin_state, cts_prev, cts_edge, chg_clear;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cts_meta <= MSR_RESET[MSR_PIN_BIT];
      cts_pin_state <= MSR_RESET[MSR_PIN_BIT];
      cts_prev <= MSR_RESET[MSR_PIN_BIT];
    end else begin
      cts_meta <= cts_pin;
      cts_pin_state <= cts_meta;
      cts_prev <= cts_pin_state;
    end
  end
  assign cts_edge = HAS_MODEM && (cts_pin_state != cts_prev);
  assign chg_clear = wr_msr && cur_strb[MSR_CHG_BIT / 8] && cur_data[MSR_CHG_BIT];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cts_change_flag <= MSR_RESET[MSR_CHG_BIT];
    end else if (cts_edge) begin
      cts_change_flag <= 1'b1;
    end else if (chg_clear) begin
      cts_change_flag <= 1'b0;
    end
  end
  assign cts_asserted = HAS_MODEM && (cts_pin_state == cts_active_level);
  assign modem_irq = cts_change_flag && modem_irq_enable;

  // ----------------------------------------
  // transmit fifo
  // ----------------------------------------
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic [CW-1:0] count;
  logic fifo_full, fifo_empty, tx_idle;
  logic [FSR_LVL_W-1:0] tx_level;
  assign fifo_full = (count == CW'(DEPTH));
  assign fifo_empty = (count == '0);
  assign push_ok = push_req && !fifo_full;
  assign pop = tx_valid && tx_ready;
  assign tx_valid = !fifo_empty;
  assign tx_byte = mem[rd_ptr];
  assign tx_idle = fifo_empty && !shift_busy;
  assign tx_level = fifo_full ? '0 : FSR_LVL_W'(count);

  always_ff @(posedge core_clk) begin
    if (push_ok) mem[wr_ptr] <= cur_data[7:0];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push_ok) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      case ({push_ok, pop})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_overflow_flag <= FSR_RESET[FSR_OVF_BIT];
    end else if (push_req && fifo_full) begin
      tx_overflow_flag <= 1'b1;
    end else if (wr_fsr && cur_strb[FSR_OVF_BIT / 8] && cur_data[FSR_OVF_BIT]) begin
      tx_overflow_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  logic [31:0] msr_value, fsr_value, rd_value;
  always_comb begin
    msr_value = 32'h0000_0000;
    if (HAS_MODEM) begin
      msr_value[MSR_LEVEL_BIT] = cts_active_level;
      msr_value[MSR_PIN_BIT] = cts_pin_state;
      msr_value[MSR_CHG_BIT] = cts_change_flag;
    end
    fsr_value = 32'h0000_0000;
    fsr_value[FSR_IDLE_BIT] = tx_idle;
    fsr_value[FSR_OVF_BIT] = tx_overflow_flag;
    fsr_value[FSR_FULL_BIT] = fifo_full;
    fsr_value[FSR_EMPTY_BIT] = fifo_empty;
    fsr_value[FSR_LVL_LSB +: FSR_LVL_W] = tx_level;
    fsr_value[FSR_RXE_BIT] = FSR_RESET[FSR_RXE_BIT];
    case (s_axi_araddr)
      OFS_IER: rd_value = {31'h0000_0000, modem_irq_enable};
      OFS_MSR: rd_value = msr_value;
      OFS_FSR: rd_value = fsr_value;
      default: rd_value = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= fn_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_full_write;
    push_req && fifo_full;
  endsequence
  sequence s_cts_toggle;
    HAS_MODEM && (cts_pin_state != cts_prev);
  endsequence
  sequence s_full_pop;
    fifo_full && pop && !push_ok;
  endsequence

  a_cts_edge_flag: assert property (s_cts_toggle |=> cts_change_flag)
    else $error("cts change did not set flag");
  a_cts_sync_delay: assert property ($changed(cts_pin_state) |-> $past(cts_pin, 2) == cts_pin_state)
    else $error("pin state not two stages behind pin");
  a_modem_irq_gate: assert property (modem_irq == (cts_change_flag && modem_irq_enable))
    else $error("modem interrupt mismatch");
  a_flag_w1c: assert property (chg_clear && !cts_edge |=> !cts_change_flag)
    else $error("change flag not cleared");
  a_no_modem_ch: assert property (!HAS_MODEM |-> msr_value == 32'h0000_0000)
    else $error("modem register not zero on channel two");
  a_ovf_no_enq: assert property (s_full_write ##0 !pop |=> tx_overflow_flag && count == $past(count))
    else $error("full write enqueued or no overflow");
  a_ovf_sticky: assert property (tx_overflow_flag && !(wr_fsr && cur_data[FSR_OVF_BIT]) |=> tx_overflow_flag)
    else $error("overflow flag lost");
  a_level_count: assert property (push_ok && !pop |=> count == $past(count) + 1'b1)
    else $error("level did not increment");
  a_full_level: assert property (fifo_full |-> tx_level == '0 && count == CW'(DEPTH))
    else $error("full level wrong");
  a_push_nonempty: assert property (push_ok |=> !fifo_empty)
    else $error("empty stuck after write");
  a_idle_flag: assert property (tx_idle |-> count == '0 && !shift_busy)
    else $error("idle while busy");
  a_full_release: assert property (s_full_pop |=> !fifo_full && tx_level == FSR_LVL_W'(DEPTH - 1))
    else $error("level after full pop wrong");
  a_level_dec: assert property (pop && !push_ok |=> count == $past(count) - 1'b1)
    else $error("level did not decrement");
  a_last_pop_empty: assert property (pop && !push_ok && count == CW'(1) |=> fifo_empty)
    else $error("empty not set after last byte");
  a_busy_not_idle: assert property ((!fifo_empty || shift_busy) |-> !tx_idle)
    else $error("idle while data pending");
  a_chg_sticky: assert property (cts_change_flag && !chg_clear |=> cts_change_flag)
    else $error("change flag lost");
  a_ovf_w1c: assert property (wr_fsr && cur_strb[FSR_OVF_BIT / 8] && cur_data[FSR_OVF_BIT]
    && !(push_req && fifo_full) |=> !tx_overflow_flag)
    else $error("overflow flag not cleared");
endmodule : ums_top
`default_nettype wire

/* File: hw/ums_pkg.sv */
package ums_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFS_TX_PORT = 8'h00;
  localparam logic [7:0] OFS_IER = 8'h04;
  localparam logic [7:0] OFS_MSR = 8'h14;
  localparam logic [7:0] OFS_FSR = 8'h18;
  localparam int IER_MODEM_BIT = 0;
  localparam int MSR_LEVEL_BIT = 8;
  localparam int MSR_PIN_BIT = 4;
  localparam int MSR_CHG_BIT = 0;
  localparam int FSR_IDLE_BIT = 28;
  localparam int FSR_OVF_BIT = 24;
  localparam int FSR_FULL_BIT = 23;
  localparam int FSR_EMPTY_BIT = 22;
  localparam int FSR_LVL_LSB = 16;
  localparam int FSR_LVL_W = 6;
  localparam int FSR_RXE_BIT = 14;
  localparam logic [31:0] MSR_RESET = 32'h0000_0110;
  localparam logic [31:0] FSR_RESET = 32'h1040_4000;
  localparam logic IER_RESET = 1'h0;
  // ----------------------------------------
  // fifo depths, bus answers
  // ----------------------------------------
  localparam int DEPTH_CH0 = 64;
  localparam int DEPTH_OTHER = 16;
  localparam int NO_MODEM_CHANNEL = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    UMS_WR_WAIT = 2'b01,
    UMS_WR_RESP = 2'b10
  } ums_wr_state_t;
endpackage : ums_pkg

/* File: bench/ums_remote.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far side: cts driver and shift register
// ----------------------------------------
module ums_remote (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cts_want,
  input wire logic stall,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic shift_busy,
  output logic cts_pin,
  output logic got,
  output logic [7:0] got_byte
);
  logic [3:0] bits_left;
  // cts moves 2 ns after the clock edge that drives cts_want
  assign #2 cts_pin = cts_want;
  assign tx_ready = !stall && bits_left == 4'h0;
  assign shift_busy = bits_left != 4'h0;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bits_left <= 4'h0;
      got <= 1'b0;
      got_byte <= 8'h00;
    end else begin
      got <= tx_valid && tx_ready;
      if (tx_valid && tx_ready) begin
        bits_left <= 4'hA;
        got_byte <= tx_byte;
      end else if (bits_left != 4'h0) begin
        bits_left <= bits_left - 4'h1;
      end
    end
  end
endmodule : ums_remote
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb import ums_pkg::*; ;
  logic core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, tx_byte, got_byte, b;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic cts_pin, cts_asserted, modem_irq, tx_valid, tx_ready, shift_busy;
  logic cts_want, stall, got;
  logic [31:0] d2, rdata_ch2;
  logic [1:0] br;
  logic cts_asserted_ch2, modem_irq_ch2;
  logic [7:0] exp_q[$];
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  ums_top u_ums_top (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cts_pin, .cts_asserted, .modem_irq, .tx_byte, .tx_valid, .tx_ready, .shift_busy);
  ums_remote u_ums_remote (.core_clk, .rst, .cts_want, .stall, .tx_byte, .tx_valid, .tx_ready,
    .shift_busy, .cts_pin, .got, .got_byte);
  // channel without modem features, shares the bus and watches in lockstep
  ums_top #(.CHANNEL(NO_MODEM_CHANNEL)) u_ums_top_ch2 (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(rdata_ch2),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .cts_pin, .cts_asserted(cts_asserted_ch2),
    .modem_irq(modem_irq_ch2), .tx_byte(), .tx_valid(), .tx_ready, .shift_busy);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic close_out();
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  function automatic logic [31:0] fsr_exp(int dep, int occ, bit ovf, bit busy);
    logic [31:0] v;
    v = 32'h0000_4000;
    v[FSR_IDLE_BIT] = occ == 0 && !busy;
    v[FSR_OVF_BIT] = ovf;
    v[FSR_FULL_BIT] = occ == dep;
    v[FSR_EMPTY_BIT] = occ == 0;
    v[FSR_LVL_LSB +: FSR_LVL_W] = FSR_LVL_W'(occ % dep);
    return v;
  endfunction : fsr_exp
  task automatic wr(logic [7:0] a, logic [31:0] v, logic [3:0] s);
    logic ah;
    logic wh;
    ah = 0;
    wh = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ah && wh)) begin
      @(posedge core_clk);
      if (!ah && s_axi_awready === 1'b1) begin
        ah = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wh && s_axi_wready === 1'b1) begin
        wh = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    d2 = rdata_ch2;
    s_axi_rready <= 1'b0;
  endtask : rd
  // ----------------------------------------
  // clock, watchdog, byte monitor
  // ----------------------------------------
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (got === 1'b1) chk("tx byte", {24'h0, exp_q.pop_front()}, {24'h0, got_byte});
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    cts_want = 1;
    stall = 1;
    repeat (6) @(posedge core_clk);
    rst <= 0;
    void'($urandom(32'h45206e42));
    rd(OFS_MSR, d);
    chk("msr", MSR_RESET, d);
    chk("msr ch2", 32'h0000_0000, d2);
    chk("rresp", RESP_OKAY, rr);
    rd(OFS_FSR, d);
    chk("fsr", FSR_RESET, d);
    chk("fsr ch2", FSR_RESET, d2);
    wr(OFS_FSR, 32'hFFFF_FFFF, 4'hF);
    chk("bresp", RESP_OKAY, br);
    rd(OFS_FSR, d);
    chk("fsr", FSR_RESET, d);
    wr(8'h40, 32'hFFFF_FFFF, 4'hF);
    chk("bresp", RESP_SLVERR, br);
    rd(8'h40, d);
    chk("rresp", RESP_SLVERR, rr);
    chk("unmapped", 32'h0000_0000, d);
    cts_want <= 1'b0;
    repeat (5) @(posedge core_clk);
    rd(OFS_MSR, d);
    chk("msr", 32'h0000_0101, d);
    chk("msr ch2", 32'h0000_0000, d2);
    chk("cts asserted", 32'h0, cts_asserted);
    chk("cts asserted ch2", 32'h0, cts_asserted_ch2);
    wr(OFS_MSR, 32'h0, 4'h3);
    chk("cts asserted", 32'h1, cts_asserted);
    chk("irq", 32'h0, modem_irq);
    rd(OFS_MSR, d);
    chk("msr", 32'h0000_0001, d);
    wr(OFS_IER, 32'h1, 4'h1);
    chk("irq", 32'h1, modem_irq);
    chk("irq ch2", 32'h0, modem_irq_ch2);
    wr(OFS_MSR, 32'h1, 4'h1);
    rd(OFS_MSR, d);
    chk("msr", 32'h0, d);
    chk("irq", 32'h0, modem_irq);
    cts_want <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd(OFS_MSR, d);
    chk("msr", 32'h0000_0011, d);
    for (int i = 0; i < DEPTH_CH0; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      wr(OFS_TX_PORT, {24'h0, b}, 4'h1);
      if (i == 0) begin
        rd(OFS_FSR, d);
        chk("fsr", fsr_exp(DEPTH_CH0, 1, 0, 0), d);
      end
    end
    rd(OFS_FSR, d);
    chk("fsr", fsr_exp(DEPTH_CH0, DEPTH_CH0, 0, 0), d);
    chk("fsr ch2", fsr_exp(DEPTH_OTHER, DEPTH_OTHER, 1, 0), d2);
    wr(OFS_TX_PORT, 32'h5A, 4'h1);
    rd(OFS_FSR, d);
    chk("fsr", fsr_exp(DEPTH_CH0, DEPTH_CH0, 1, 0), d);
    wr(OFS_FSR, 32'h0, 4'h8);
    rd(OFS_FSR, d);
    chk("fsr", fsr_exp(DEPTH_CH0, DEPTH_CH0, 1, 0), d);
    wr(OFS_FSR, 32'h0100_0000, 4'h8);
    rd(OFS_FSR, d);
    chk("fsr", fsr_exp(DEPTH_CH0, DEPTH_CH0, 0, 0), d);
    chk("fsr ch2", fsr_exp(DEPTH_OTHER, DEPTH_OTHER, 0, 0), d2);
    stall <= 1'b0;
    @(posedge core_clk iff got === 1'b1);
    stall <= 1'b1;
    rd(OFS_FSR, d);
    chk("fsr", fsr_exp(DEPTH_CH0, DEPTH_CH0 - 1, 0, 1), d);
    chk("fsr ch2", fsr_exp(DEPTH_OTHER, DEPTH_OTHER - 1, 0, 1), d2);
    stall <= 1'b0;
    do @(posedge core_clk); while (tx_valid === 1'b1);
    rd(OFS_FSR, d);
    chk("fsr", fsr_exp(DEPTH_CH0, 0, 0, 1), d);
    repeat (12) @(posedge core_clk);
    rd(OFS_FSR, d);
    chk("fsr", fsr_exp(DEPTH_CH0, 0, 0, 0), d);
    chk("fsr ch2", FSR_RESET, d2);
    close_out();
  end
endmodule : tb
`default_nettype wire
